// File: hw/oscp_consts.vh
// Constants for the output source select and PLL configuration register bank.
// Assumes a byte-wide register port from an outside serial-bus slave.
// Summary of operation
// [R1] Rising sync bit holds all PLL-fed output dividers in reset while set.
// [R2] Falling sync bit releases dividers together and clears coarse phase.
// [R3] Outputs four to seven each pick a source through a 3-bit selector.
// [R4] Host must not route references above 250MHz directly to outputs.
// [R5] Reset selectors: out4 and out6 PLL, out5 output two, out7 reference one.
// [R6] Synthesizer mode bit: clear tracks references, set uses crystal only.
// [R7] Host forces free-run state whenever it sets synthesizer mode.
// [R8] Lock override bit resets clear; clear automatic, set manual lock control.
// [R9] Manual oscillator select: clear second, set first; resets set.
// [R10] Two 5-bit manual lock codes, resetting to 01011b and 00000b.
// [R11] Lock count bit: clear 1 ppm, set 16 ppm; resets set.
// [R12] 3-bit charge pump current code in eight steps, resetting to 100b.
// [R13] Loop filter: resistor 01b, capacitor 01b, second pole one at reset.
// [R14] Host writes zero to reserved bits; their read values are undefined.
// [R15] Fine phase takes effect only on a sync toggle; toggling clears coarse.
// [R16] A reserved source code holds that output's clock path static.
`ifndef OSCP_CONSTS_VH
`define OSCP_CONSTS_VH
`define OSCP_ADDR_SYNC      8'hA8
`define OSCP_ADDR_SEL45     8'hA9
`define OSCP_ADDR_SEL67     8'hAA
`define OSCP_ADDR_PUMP      8'hAC
`define OSCP_ADDR_LOCK      8'hAD
`define OSCP_ADDR_OSC1      8'hAE
`define OSCP_ADDR_CODE2     8'hAF
`define OSCP_SYNC_BIT       4
`define OSCP_SRC_PLL        3'h0
`define OSCP_SRC_RSV1       3'h1
`define OSCP_SRC_OUT2       3'h2
`define OSCP_SRC_OUT3       3'h3
`define OSCP_SRC_REF0       3'h4
`define OSCP_SRC_REF1       3'h5
`define OSCP_SRC_RSV6       3'h6
`define OSCP_SRC_XTAL       3'h7
`define OSCP_RST_SEL4       3'h0
`define OSCP_RST_SEL5       3'h2
`define OSCP_RST_SEL6       3'h0
`define OSCP_RST_SEL7       3'h5
`define OSCP_RST_PUMP       3'h4
`define OSCP_RST_RES        2'h1
`define OSCP_RST_CAP        2'h1
`define OSCP_RST_POLE       1'h1
`define OSCP_RST_SYNTH      1'h0
`define OSCP_RST_LCNT       1'h1
`define OSCP_RST_OVR        1'h0
`define OSCP_RST_OSCSEL     1'h1
`define OSCP_RST_CODE1      5'h0B
`define OSCP_RST_CODE2      5'h00
`endif

// File: hw/oscp_config.v
// Register bank that selects sources for outputs four to seven and holds PLL settings.
// Assumes an outside serial-bus slave presents a byte address, write strobe and data
// on the mclk domain; analog parts consume the configuration outputs.
`timescale 1ns/10ps
`default_nettype none
`include "oscp_consts.vh"
module oscp_config
(
    input  wire        mclk,
    input  wire        rst,
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         output_divider_sync,
    output reg         divider_hold,
    output reg         divider_release,
    output reg         coarse_phase_clear,
    output reg  [2:0]  out4_source_select,
    output reg  [2:0]  out5_source_select,
    output reg  [2:0]  out6_source_select,
    output reg  [2:0]  out7_source_select,
    output reg  [3:0]  out_path_static,
    output reg  [2:0]  pump_current_setting,
    output reg  [1:0]  loop_series_resistor,
    output reg  [1:0]  loop_parallel_capacitor,
    output reg         loop_second_pole,
    output reg         synthesizer_mode_select,
    output reg         lock_count_precision,
    output reg         lock_override_mode,
    output reg         manual_oscillator_select,
    output reg  [4:0]  manual_lock_code_first,
    output reg  [4:0]  manual_lock_code_second,
    output reg  [4:0]  active_lock_code
);

    // Address decode of the write strobe, one enable per mapped register.
    // Each enable is high only in the cycle that the outside slave presents reg_wr.
    // Writes to any other address, the unmapped one between the selectors and
    // the loop filter included, match no enable and so change nothing.
    // Reserved data bits of a mapped register are simply never stored.
    wire wr_sync  = reg_wr && (reg_addr == `OSCP_ADDR_SYNC);
    wire wr_sel45 = reg_wr && (reg_addr == `OSCP_ADDR_SEL45);
    wire wr_sel67 = reg_wr && (reg_addr == `OSCP_ADDR_SEL67);
    wire wr_pump  = reg_wr && (reg_addr == `OSCP_ADDR_PUMP);
    wire wr_lock  = reg_wr && (reg_addr == `OSCP_ADDR_LOCK);
    wire wr_osc1  = reg_wr && (reg_addr == `OSCP_ADDR_OSC1);
    wire wr_code2 = reg_wr && (reg_addr == `OSCP_ADDR_CODE2);

    // Next value of the sync bit and its edges.
    wire nxt_sync = wr_sync ? reg_wdata[`OSCP_SYNC_BIT] : output_divider_sync;
    wire sync_rise = nxt_sync && !output_divider_sync;
    wire sync_fall = !nxt_sync && output_divider_sync;

    // Sync bit with its hold level and one-cycle release and coarse-clear pulses.
    // The hold level follows the stored bit, so the dividers stay in reset while it is set.
    // Release and coarse clear are one pulse, so every divider restarts on the same edge.
    // A write of the same value makes no edge and therefore no extra pulse.
    // Fine phase values are picked up elsewhere on the release pulse.
    always @(posedge mclk)
    begin
        if (rst)
        begin
            output_divider_sync <= 1'b0;
            divider_hold        <= 1'b0;
            divider_release     <= 1'b0;
            coarse_phase_clear  <= 1'b0;
        end
        else
        begin
            output_divider_sync <= nxt_sync;
            divider_hold        <= nxt_sync;  // [R1]
            divider_release     <= sync_fall; // [R2] [R15]
            coarse_phase_clear  <= sync_fall; // [R2] [R15]
        end
    end

    // Source selectors; reserved data bits are not stored.
    // The lower field of each byte feeds the even output and the upper field the odd one.
    // Every code, reserved ones too, is stored so that a read returns what was written.
    // Routing a fast reference straight through is left to the host to avoid.
    always @(posedge mclk)
    begin
        if (rst)
        begin
            out4_source_select <= `OSCP_RST_SEL4; // [R5]
            out5_source_select <= `OSCP_RST_SEL5; // [R5]
            out6_source_select <= `OSCP_RST_SEL6; // [R5]
            out7_source_select <= `OSCP_RST_SEL7; // [R5]
        end
        else
        begin
            if (wr_sel45)
            begin
                out4_source_select <= reg_wdata[2:0]; // [R3]
                out5_source_select <= reg_wdata[6:4]; // [R3]
            end
            if (wr_sel67)
            begin
                out6_source_select <= reg_wdata[2:0]; // [R3]
                out7_source_select <= reg_wdata[6:4]; // [R3]
            end
        end
    end

    // Reserved source codes hold the matching output path static.
    // This keeps an undefined code from forwarding an arbitrary clock to an output.
    // The check is shared by all four selectors.
    function rsv_code;
        input [2:0] sel;
        begin
            rsv_code = (sel == `OSCP_SRC_RSV1) || (sel == `OSCP_SRC_RSV6);
        end
    endfunction

    wire [3:0] nxt_static = {rsv_code(out7_source_select), rsv_code(out6_source_select),
                             rsv_code(out5_source_select), rsv_code(out4_source_select)};

    // Static flags are registered one cycle after the selector.
    always @(posedge mclk)
    begin
        if (rst)
            out_path_static <= 4'h0;
        else
            out_path_static <= nxt_static; // [R16]
    end

    // Analog PLL settings.
    // Pump and filter fields only tune the analog loop; the lock override, select and codes feed active_lock_code below.
    // The charge pump code steps the current evenly from lowest to highest.
    // The lock count precision should be cleared by the host for a large loop capacitor.
    // Setting synthesizer mode also needs the host to force the free-run state elsewhere.
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pump_current_setting     <= `OSCP_RST_PUMP;   // [R12]
            loop_series_resistor     <= `OSCP_RST_RES;    // [R13]
            loop_parallel_capacitor  <= `OSCP_RST_CAP;    // [R13]
            loop_second_pole         <= `OSCP_RST_POLE;   // [R13]
            synthesizer_mode_select  <= `OSCP_RST_SYNTH;  // [R6]
            lock_count_precision     <= `OSCP_RST_LCNT;   // [R11]
            lock_override_mode       <= `OSCP_RST_OVR;    // [R8]
            manual_oscillator_select <= `OSCP_RST_OSCSEL; // [R9]
            manual_lock_code_first   <= `OSCP_RST_CODE1;  // [R10]
            manual_lock_code_second  <= `OSCP_RST_CODE2;  // [R10]
        end
        else
        begin
            if (wr_pump)
            begin
                pump_current_setting    <= reg_wdata[7:5]; // [R12]
                loop_series_resistor    <= reg_wdata[4:3]; // [R13]
                loop_parallel_capacitor <= reg_wdata[2:1]; // [R13]
                loop_second_pole        <= reg_wdata[0];   // [R13]
            end
            if (wr_lock)
            begin
                synthesizer_mode_select <= reg_wdata[3]; // [R6]
                lock_count_precision    <= reg_wdata[1]; // [R11]
                lock_override_mode      <= reg_wdata[0]; // [R8]
            end
            if (wr_osc1)
            begin
                manual_oscillator_select <= reg_wdata[5];   // [R9]
                manual_lock_code_first   <= reg_wdata[4:0]; // [R10]
            end
            if (wr_code2)
                manual_lock_code_second <= reg_wdata[4:0]; // [R10]
        end
    end

    // Lock code applied to the oscillator: zero in automatic mode, else the chosen code.
    // The code is registered, so it follows a mode or selector change one cycle later.
    // Both stored codes keep their values while automatic mode is in force.
    // Zero is a neutral value that the automatic lock logic ignores.
    always @(posedge mclk)
    begin
        if (rst)
            active_lock_code <= 5'h00;
        else if (!lock_override_mode)
            active_lock_code <= 5'h00; // [R8]
        else if (manual_oscillator_select)
            active_lock_code <= manual_lock_code_first; // [R9]
        else
            active_lock_code <= manual_lock_code_second; // [R9]
    end

    // Read data, registered; reserved bits read as zero.
    // Zero is one legal choice for bits whose read value is left undefined.
    // Unmapped addresses also read zero so that a stray read is harmless.
    // The mux is decoded from the address of the current cycle.
    reg [7:0] nxt_rdata;
    always @*
    begin
        nxt_rdata = 8'h00;
        case (reg_addr)
            `OSCP_ADDR_SYNC:  nxt_rdata = {3'h0, output_divider_sync, 4'h0};
            `OSCP_ADDR_SEL45: nxt_rdata = {1'b0, out5_source_select, 1'b0, out4_source_select};
            `OSCP_ADDR_SEL67: nxt_rdata = {1'b0, out7_source_select, 1'b0, out6_source_select};
            `OSCP_ADDR_PUMP:  nxt_rdata = {pump_current_setting, loop_series_resistor,
                                           loop_parallel_capacitor, loop_second_pole};
            `OSCP_ADDR_LOCK:  nxt_rdata = {4'h0, synthesizer_mode_select, 1'b0,
                                           lock_count_precision, lock_override_mode}; // [R14]
            `OSCP_ADDR_OSC1:  nxt_rdata = {2'h0, manual_oscillator_select,
                                           manual_lock_code_first};
            `OSCP_ADDR_CODE2: nxt_rdata = {3'h0, manual_lock_code_second};
            default:          nxt_rdata = 8'h00;
        endcase
    end

    // Read data register; data for an address stands one cycle after it.
    // A host must therefore hold the address for one edge before it takes the data.
    // The register keeps the port output straight from a flip-flop.
    // Reset clears it so that the port never shows an unknown value.
    always @(posedge mclk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= nxt_rdata;
    end

endmodule
`default_nettype wire

// File: verif/oscp_config_asserts.sv
// Assertions on the ports of the source select and PLL setting bank.
// Assumes binding to oscp_config on the single mclk domain.
`timescale 1ns/10ps
`default_nettype none
module oscp_config_asserts
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       output_divider_sync,
    input wire logic       divider_hold,
    input wire logic       divider_release,
    input wire logic       coarse_phase_clear,
    input wire logic [2:0] out4_source_select,
    input wire logic [3:0] out_path_static,
    input wire logic       lock_override_mode,
    input wire logic       manual_oscillator_select,
    input wire logic [4:0] manual_lock_code_first,
    input wire logic [4:0] manual_lock_code_second,
    input wire logic [4:0] active_lock_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Each check ties an output to the write or state that caused it.
    a_sync_store: assert property (
        reg_wr && reg_addr == 8'hA8 |=> output_divider_sync == $past(reg_wdata[4]))
        else $error("sync bit not stored");
    a_hold_level: assert property (
        divider_hold == output_divider_sync)
        else $error("divider hold not following sync bit");
    a_release_fall: assert property (
        $fell(output_divider_sync) |-> divider_release && coarse_phase_clear)
        else $error("no release on sync fall");
    a_release_once: assert property (
        divider_release |=> !divider_release && !coarse_phase_clear)
        else $error("release pulse too long");
    a_sel_store: assert property (
        reg_wr && reg_addr == 8'hA9 |=> out4_source_select == $past(reg_wdata[2:0]))
        else $error("selector not stored");
    a_static_rsv: assert property (
        out4_source_select inside {3'h1, 3'h6} |=> out_path_static[0])
        else $error("reserved source not static");
    a_auto_code: assert property (
        !lock_override_mode |=> active_lock_code == 5'h00)
        else $error("code active in automatic mode");
    a_first_code: assert property (
        lock_override_mode && manual_oscillator_select
        |=> active_lock_code == $past(manual_lock_code_first))
        else $error("first code not used");
    a_second_code: assert property (
        lock_override_mode && !manual_oscillator_select
        |=> active_lock_code == $past(manual_lock_code_second))
        else $error("second code not used");
    a_unmapped_zero: assert property (
        reg_addr == 8'hAB |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// File: verif/oscp_host.sv
// Host model driving the byte register port.
// Assumes one clock; callers keep reserved bits zero.
`timescale 1ns/10ps
`default_nettype none
module oscp_host
(
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_wdata
);
    // Idle bus at time zero.
    initial {reg_addr, reg_wr, reg_wdata} = 17'h0;
    // One write taken at a single edge; data inverted once released.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Read data arrives one cycle after the address.
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        @(posedge mclk);
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the source select and PLL setting bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, output_divider_sync, divider_hold, divider_release, coarse_phase_clear;
    wire  [2:0] out4_source_select, out5_source_select, out6_source_select, out7_source_select;
    wire  [2:0] pump_current_setting;
    wire  [3:0] out_path_static;
    wire  [1:0] loop_series_resistor, loop_parallel_capacitor;
    wire        loop_second_pole, synthesizer_mode_select, lock_count_precision;
    wire        lock_override_mode, manual_oscillator_select;
    wire  [4:0] manual_lock_code_first, manual_lock_code_second, active_lock_code;
    int         error_cnt = 0;
    int         comparisons = 0;
    logic [7:0] rv;
    oscp_config oscp_config_i (.*);
    oscp_host oscp_host_i (.*);
    // Clock of 50 ns period.
    initial forever #25 mclk = ~mclk;
    task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask
    task t_reset;
        logic [7:0] a [6] = '{8'hA9, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF};
        logic [7:0] e [6] = '{8'h20, 8'h50, 8'h8B, 8'h02, 8'h2B, 8'h00};
        chk("hold", {divider_hold, active_lock_code}, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            oscp_host_i.rd(a[i], rv);
            chk("reset read", rv, e[i]);
        end
        $display("reset test done");
    endtask
    task t_sync;
        oscp_host_i.wr(8'hA8, 8'h10);
        repeat (3) @(posedge mclk);
        #1 chk("hold", divider_hold, 8'h01);
        oscp_host_i.rd(8'hA8, rv);
        chk("sync read", rv, 8'h10);
        oscp_host_i.wr(8'hA8, 8'h00);
        #1 chk("release", {divider_release, coarse_phase_clear, divider_hold}, 8'h06);
        @(posedge mclk);
        #1 chk("pulse end", {divider_release, coarse_phase_clear}, 8'h00);
        $display("sync test done");
    endtask
    task t_sel;
        for (int c = 0; c < 8; c++)
        begin
            oscp_host_i.wr(8'hA9, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
            @(posedge mclk);
            #1 chk("sel", {out5_source_select, out4_source_select}, 8'(8 * (7 - c) + c));
            chk("static", out_path_static, (c == 1 || c == 6) ? 8'h03 : 8'h00);
        end
        oscp_host_i.wr(8'hAA, 8'h16);
        @(posedge mclk);
        #1 chk("sel67", {out7_source_select, out6_source_select}, 8'h0E);
        chk("static67", out_path_static, 8'h0C);
        $display("select test done");
    endtask
    task t_lock;
        oscp_host_i.wr(8'hAE, 8'h35);
        oscp_host_i.wr(8'hAF, 8'h0A);
        oscp_host_i.wr(8'hAD, 8'h09);
        @(posedge mclk);
        #1 chk("first", active_lock_code, 8'h15);
        chk("mode", {synthesizer_mode_select, lock_count_precision}, 8'h02);
        oscp_host_i.wr(8'hAE, 8'h15);
        @(posedge mclk);
        #1 chk("second", active_lock_code, 8'h0A);
        oscp_host_i.wr(8'hAC, 8'h74);
        #1 chk("filter", {pump_current_setting, loop_series_resistor,
            loop_parallel_capacitor, loop_second_pole}, 8'h74);
        oscp_host_i.wr(8'hAD, 8'h00);
        @(posedge mclk);
        #1 chk("auto", active_lock_code, 8'h00);
        oscp_host_i.wr(8'hAB, 8'hFF);
        oscp_host_i.rd(8'hAB, rv);
        chk("unmapped", rv, 8'h00);
        oscp_host_i.rd(8'hAF, rv);
        chk("kept", rv, 8'h0A);
        $display("lock test done");
    endtask
    task end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence after a 12-cycle reset.
    initial
    begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_sync;
        t_sel;
        t_lock;
        end_sim;
    end
    // Bound on the whole run.
    initial
    begin
        repeat (2000) @(posedge mclk);
        error_cnt++;
        end_sim;
    end
endmodule
bind oscp_config oscp_config_asserts chk_i (.*);
`default_nettype wire
